// >>> hdl/dma_channel_engine.v
`timescale 1ns/1ps
`include "dma_channel_defines.vh"

module dma_channel_engine #(
    parameter NUM_CH = 4,
    parameter CH_ID  = 0
) (
    input  wire                  SYS_CLK,
    input  wire                  SRST,
    input  wire [31:0]           AVS_ADDRESS,
    input  wire                  AVS_READ,
    input  wire                  AVS_WRITE,
    input  wire [31:0]           AVS_WRITEDATA,
    input  wire [3:0]            AVS_BYTEENABLE,
    output wire [31:0]           AVS_READDATA,
    output wire                  AVS_WAITREQUEST,
    input  wire                  PERIPH_REQ,
    input  wire [NUM_CH-1:0]     PEER_REQ,
    input  wire [3*NUM_CH-1:0]   PEER_PRIO,
    input  wire [NUM_CH-1:0]     PEER_LOCK,
    output wire                  BUS_REQ,
    output wire [2:0]            BUS_PRIO,
    output wire                  BUS_LOCK,
    output wire [31:0]           M_ADDRESS,
    output wire                  M_READ,
    output wire                  M_WRITE,
    output wire [31:0]           M_WRITEDATA,
    output wire [1:0]            M_WIDTH,
    input  wire [31:0]           M_READDATA,
    input  wire                  M_WAITREQUEST,
    output wire                  IRQ
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_WAIT = 3'h1;
    localparam [2:0] ST_ARB  = 3'h2;
    localparam [2:0] ST_READ = 3'h3;
    localparam [2:0] ST_WRIT = 3'h4;
    localparam [2:0] ST_GAP  = 3'h5;

    reg  [15:0] src_low_ff;
    reg  [15:0] src_high_ff;
    reg  [15:0] dst_low_ff;
    reg  [15:0] dst_high_ff;
    reg  [15:0] threshold_ff;
    reg  [15:0] length_ff;
    reg  [15:0] control_ff;
    reg  [15:0] item_index_ff;
    reg  [15:0] nxt_item_index;
    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg         nxt_on_clear;
    reg         ack_ff;
    reg  [31:0] readdata_ff;
    reg  [15:0] rd_mux;
    reg         sync1_ff;
    reg         sync2_ff;
    reg         req_prev_ff;
    reg         edge_pend_ff;
    reg         consume;
    reg  [31:0] data_ff;
    reg         data_valid_ff;
    reg  [31:0] m_addr_ff;
    reg         m_read_ff;
    reg         m_write_ff;
    reg         irq_ff;
    reg         nxt_irq;
    reg         win;
    reg  [2:0]  peer_p;
    reg  [31:0] step_base;
    reg  [31:0] src_step;
    reg  [31:0] dst_step;
    reg  [31:0] nxt_m_addr;
    integer     i;

    wire        bus_cycle   = AVS_READ | AVS_WRITE;
    wire        wr_hit      = AVS_WRITE & ack_ff;
    wire        ch_on       = control_ff[`CTL_ON];
    wire [1:0]  width_code  = control_ff[`CTL_WIDTH_HI:`CTL_WIDTH_LO];
    wire        triggered   = control_ff[`CTL_TRIG_MODE];
    wire        fill_mode   = control_ff[`CTL_FILL];
    wire [2:0]  my_prio     = control_ff[`CTL_PRIO_HI:`CTL_PRIO_LO];
    wire        steal_mode  = control_ff[`CTL_STEAL] & ~triggered;
    wire        hold_bus    = fill_mode | (~control_ff[`CTL_STEAL] & ~triggered);
    wire        busy        = (state_ff == ST_READ) | (state_ff == ST_WRIT);
    wire        last_item   = (item_index_ff == length_ff);
    wire        req_seen    = control_ff[`CTL_EDGE_SENSE] ? edge_pend_ff : sync2_ff;
    wire [31:0] src_start   = {src_high_ff, src_low_ff};
    wire [31:0] dst_start   = {dst_high_ff, dst_low_ff};

    // Avalon slave: one wait state, then the answer.
    assign AVS_WAITREQUEST = bus_cycle & ~ack_ff;
    assign AVS_READDATA    = readdata_ff;

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_cycle & ~ack_ff;
        end
    end

    always @* begin
        case (AVS_ADDRESS)
            `IDX_ITEM_INDEX:     rd_mux = item_index_ff;
            `IDX_SRC_START_LOW:  rd_mux = src_low_ff;
            `IDX_SRC_START_HIGH: rd_mux = src_high_ff;
            `IDX_DST_START_LOW:  rd_mux = dst_low_ff;
            `IDX_DST_START_HIGH: rd_mux = dst_high_ff;
            `IDX_IRQ_THRESHOLD:  rd_mux = threshold_ff;
            `IDX_XFER_LENGTH:    rd_mux = length_ff;
            `IDX_CONTROL_WORD:   rd_mux = control_ff & `CTL_WRITE_MASK;
            default:             rd_mux = `RST_REG16;
        endcase
    end

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            readdata_ff <= `RST_DATA32;
        end else if (AVS_READ & ~ack_ff) begin
            readdata_ff <= {16'h0000, rd_mux};
        end
    end

    // Write of one 16-bit register under the two low byte enables.
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wd;
        input [1:0]  be;
        begin
            merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            src_low_ff   <= `RST_REG16;
            src_high_ff  <= `RST_REG16;
            dst_low_ff   <= `RST_REG16;
            dst_high_ff  <= `RST_REG16;
            threshold_ff <= `RST_REG16;
            length_ff    <= `RST_REG16;
        end else if (wr_hit) begin
            if (AVS_ADDRESS == `IDX_SRC_START_LOW) begin
                src_low_ff <= merge16(src_low_ff, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);
            end
            if (AVS_ADDRESS == `IDX_SRC_START_HIGH) begin
                src_high_ff <= merge16(src_high_ff, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);
            end
            if (AVS_ADDRESS == `IDX_DST_START_LOW) begin
                dst_low_ff <= merge16(dst_low_ff, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);
            end
            if (AVS_ADDRESS == `IDX_DST_START_HIGH) begin
                dst_high_ff <= merge16(dst_high_ff, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);
            end
            if (AVS_ADDRESS == `IDX_IRQ_THRESHOLD) begin
                threshold_ff <= merge16(threshold_ff, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);
            end
            if (AVS_ADDRESS == `IDX_XFER_LENGTH) begin
                length_ff <= merge16(length_ff, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);
            end
        end
    end

    // A software write of the control word wins over the hardware clear of the on bit.
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            control_ff <= `RST_REG16;
        end else if (wr_hit && AVS_ADDRESS == `IDX_CONTROL_WORD) begin
            control_ff <= merge16(control_ff, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0])
                          & `CTL_WRITE_MASK;
        end else if (nxt_on_clear) begin
            control_ff[`CTL_ON] <= 1'b0;
        end
    end

    // Peripheral request: two-stage synchroniser, then edge detection.
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            sync1_ff     <= 1'b0;
            sync2_ff     <= 1'b0;
            req_prev_ff  <= 1'b0;
            edge_pend_ff <= 1'b0;
        end else begin
            sync1_ff    <= PERIPH_REQ;
            sync2_ff    <= sync1_ff;
            req_prev_ff <= sync2_ff;
            if (sync2_ff & ~req_prev_ff & ch_on) begin
                edge_pend_ff <= 1'b1;
            end else if (consume | ~ch_on) begin
                edge_pend_ff <= 1'b0;
            end
        end
    end

    // Distributed arbitration against the peer channels.
    always @* begin
        win = 1'b1;
        peer_p = 3'h0;
        for (i = 0; i < NUM_CH; i = i + 1) begin
            peer_p = PEER_PRIO[3*i +: 3];
            if (i != CH_ID) begin
                if (PEER_LOCK[i]) begin
                    win = 1'b0;
                end
                if (PEER_REQ[i] && (peer_p > my_prio)) begin
                    win = 1'b0;
                end
                if (PEER_REQ[i] && (peer_p == my_prio) && (i < CH_ID)) begin
                    win = 1'b0;
                end
            end
        end
    end

    assign BUS_REQ  = (state_ff == ST_ARB) | busy;
    assign BUS_PRIO = my_prio;
    assign BUS_LOCK = busy & hold_bus;

    // Address step per item; width code 11 gives no step.
    always @* begin
        case (width_code)
            `WIDTH_BYTE: step_base = {16'h0000, nxt_item_index};
            `WIDTH_HALF: step_base = {15'h0000, nxt_item_index, 1'b0};
            `WIDTH_WORD: step_base = {14'h0000, nxt_item_index, 2'b00};
            default:     step_base = 32'h0000_0000;
        endcase
    end

    always @* begin
        if (control_ff[`CTL_SRC_INC]) begin
            src_step = step_base;
        end else begin
            src_step = 32'h0000_0000;
        end
        if (control_ff[`CTL_DST_INC]) begin
            dst_step = step_base;
        end else begin
            dst_step = 32'h0000_0000;
        end
    end

    always @* begin
        if (nxt_state == ST_READ) begin
            nxt_m_addr = src_start + src_step;
        end else begin
            nxt_m_addr = dst_start + dst_step;
        end
    end

    always @* begin
        nxt_state      = state_ff;
        nxt_item_index = item_index_ff;
        nxt_on_clear   = 1'b0;
        nxt_irq        = 1'b0;
        consume        = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_item_index = 16'h0000;
                if (ch_on) begin
                    nxt_state = triggered ? ST_WAIT : ST_ARB;
                end
            end
            ST_WAIT: begin
                if (req_seen) begin
                    consume   = 1'b1;
                    nxt_state = ST_ARB;
                end
            end
            ST_ARB: begin
                if (win) begin
                    nxt_state = (fill_mode & data_valid_ff) ? ST_WRIT : ST_READ;
                end
            end
            ST_READ: begin
                if (~M_WAITREQUEST) begin
                    nxt_state = ST_WRIT;
                end
            end
            ST_WRIT: begin
                if (~M_WAITREQUEST) begin
                    if (control_ff[`CTL_IRQ_EN] && threshold_ff == item_index_ff) begin
                        nxt_irq = 1'b1;
                    end
                    if (last_item) begin
                        nxt_item_index = 16'h0000;
                        if (control_ff[`CTL_CIRCULAR] & triggered) begin
                            nxt_state = ST_WAIT;
                        end else begin
                            nxt_on_clear = 1'b1;
                            nxt_state    = ST_IDLE;
                        end
                    end else begin
                        nxt_item_index = item_index_ff + 16'h0001;
                        if (hold_bus) begin
                            nxt_state = fill_mode ? ST_WRIT : ST_READ;
                        end else if (steal_mode) begin
                            nxt_state = ST_GAP;
                        end else begin
                            nxt_state = ST_WAIT;
                        end
                    end
                end
            end
            ST_GAP: begin
                nxt_state = ST_ARB;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (~ch_on) begin
            nxt_state      = ST_IDLE;
            nxt_item_index = 16'h0000;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            state_ff      <= ST_IDLE;
            item_index_ff <= `RST_REG16;
            data_ff       <= `RST_DATA32;
            data_valid_ff <= 1'b0;
            m_addr_ff     <= `RST_DATA32;
            m_read_ff     <= 1'b0;
            m_write_ff    <= 1'b0;
            irq_ff        <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            item_index_ff <= nxt_item_index;
            irq_ff        <= nxt_irq;
            m_read_ff     <= (nxt_state == ST_READ);
            m_write_ff    <= (nxt_state == ST_WRIT);
            m_addr_ff     <= nxt_m_addr;
            if (state_ff == ST_READ && ~M_WAITREQUEST) begin
                data_ff       <= M_READDATA;
                data_valid_ff <= 1'b1;
            end else if (nxt_state == ST_IDLE || nxt_item_index == 16'h0000) begin
                data_valid_ff <= 1'b0;
            end
        end
    end

    assign M_ADDRESS   = m_addr_ff;
    assign M_READ      = m_read_ff;
    assign M_WRITE     = m_write_ff;
    assign M_WRITEDATA = data_ff;
    assign M_WIDTH     = width_code;
    assign IRQ         = irq_ff;

endmodule // dma_channel_engine

// >>> hdl/dma_channel_defines.vh
`ifndef DMA_CHANNEL_DEFINES_VH
`define DMA_CHANNEL_DEFINES_VH

// Register indices on the slave word address.
`define IDX_ITEM_INDEX      32'h5000_361E
`define IDX_SRC_START_LOW   32'h5000_3620
`define IDX_SRC_START_HIGH  32'h5000_3622
`define IDX_DST_START_LOW   32'h5000_3624
`define IDX_DST_START_HIGH  32'h5000_3626
`define IDX_IRQ_THRESHOLD   32'h5000_3628
`define IDX_XFER_LENGTH     32'h5000_362A
`define IDX_CONTROL_WORD    32'h5000_362C

// Control word field positions.
`define CTL_ON              0
`define CTL_WIDTH_LO        1
`define CTL_WIDTH_HI        2
`define CTL_IRQ_EN          3
`define CTL_TRIG_MODE       4
`define CTL_DST_INC         5
`define CTL_SRC_INC         6
`define CTL_CIRCULAR        7
`define CTL_PRIO_LO         8
`define CTL_PRIO_HI         10
`define CTL_STEAL           11
`define CTL_FILL            12
`define CTL_EDGE_SENSE      13
`define CTL_WRITE_MASK      16'h3FFF

// Reset values.
`define RST_REG16           16'h0000
`define RST_DATA32          32'h0000_0000

// Bus width codes.
`define WIDTH_BYTE          2'h0
`define WIDTH_HALF          2'h1
`define WIDTH_WORD          2'h2

`endif

// >>> bench/dma_channel_engine_props.sv
`timescale 1ns/1ps
`include "dma_channel_defines.vh"
module dma_channel_engine_props (
    input wire        SYS_CLK,
    input wire        SRST,
    input wire [31:0] AVS_ADDRESS,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [31:0] AVS_READDATA,
    input wire        AVS_WAITREQUEST,
    input wire        BUS_REQ,
    input wire        BUS_LOCK,
    input wire [2:0]  BUS_PRIO,
    input wire        M_READ,
    input wire        M_WRITE,
    input wire [31:0] M_ADDRESS,
    input wire        M_WAITREQUEST,
    input wire        IRQ
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    AST_ONE_WAIT: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("register access not answered after one wait");
    AST_RSVD_ZERO: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS == `IDX_CONTROL_WORD |-> AVS_READDATA[15:14] == 2'b00)
        else $error("reserved control bits read nonzero");
    AST_PRIO_OUT: assert property (AVS_WRITE && !AVS_WAITREQUEST
        && AVS_ADDRESS == `IDX_CONTROL_WORD |=> BUS_PRIO == $past(AVS_WRITEDATA[10:8]))
        else $error("bus priority differs from control word");
    AST_IRQ_PULSE: assert property (IRQ |=> !IRQ) else $error("irq longer than a pulse");
    AST_IRQ_CAUSE: assert property (IRQ |-> $past(M_WRITE && !M_WAITREQUEST))
        else $error("irq without a finished store");
    AST_LOCK_REQ: assert property (BUS_LOCK |-> BUS_REQ) else $error("lock without request");
    AST_MEM_HOLD: assert property ((M_READ || M_WRITE) && M_WAITREQUEST
        |=> $stable({M_READ, M_WRITE, M_ADDRESS})) else $error("memory request changed early");
    AST_RW_EXCL: assert property (!(M_READ && M_WRITE)) else $error("load and store together");
    AST_MEM_REQ: assert property ((M_READ || M_WRITE) |-> BUS_REQ)
        else $error("memory access without bus request");
endmodule // dma_channel_engine_props
bind dma_channel_engine dma_channel_engine_props i_props (.SYS_CLK(SYS_CLK), .SRST(SRST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .BUS_REQ(BUS_REQ), .BUS_LOCK(BUS_LOCK),
    .BUS_PRIO(BUS_PRIO), .M_READ(M_READ), .M_WRITE(M_WRITE), .M_ADDRESS(M_ADDRESS),
    .M_WAITREQUEST(M_WAITREQUEST), .IRQ(IRQ));

// >>> bench/mem_partner.sv
`timescale 1ns/1ps
module mem_partner (
    input  wire        clk,
    input  wire        rst,
    input  wire [31:0] addr,
    input  wire        rd,
    input  wire        wr,
    input  wire [31:0] wdata,
    input  wire [1:0]  stall,
    output reg  [31:0] rdata,
    output wire        waitreq
);
    reg     [1:0]  cnt;
    reg     [31:0] last;
    reg     [31:0] wr_addr [0:63];
    reg     [31:0] wr_data [0:63];
    integer        wr_cnt;
    integer        rd_cnt;
    // Each access is held off for stall cycles, so answers can be prompt or slow.
    assign waitreq = (rd | wr) & (cnt != stall);
    // Outside an accepted load the data lines show the inverse of the last value.
    always @* begin
        rdata = (rd && !waitreq) ? (addr ^ 32'h5A5A_0000) : ~last;
    end
    always @(posedge clk) begin
        if (rst) begin
            cnt <= 2'h0;
            last <= 32'h0000_0000;
            wr_cnt <= 0;
            rd_cnt <= 0;
        end else if (waitreq) begin
            cnt <= cnt + 2'h1;
        end else if (rd) begin
            cnt <= 2'h0;
            last <= rdata;
            rd_cnt <= rd_cnt + 1;
        end else if (wr) begin
            cnt <= 2'h0;
            wr_addr[wr_cnt[5:0]] <= addr;
            wr_data[wr_cnt[5:0]] <= wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule // mem_partner

// >>> bench/dma_channel_engine_tb.sv
`timescale 1ns/1ps
`include "dma_channel_defines.vh"
module dma_channel_engine_tb;
    reg         sys_clk = 1'b0;
    reg         srst = 1'b1;
    reg  [31:0] avs_address = 32'h0000_0000;
    reg  [31:0] avs_writedata = 32'h0000_0000;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg         periph_req = 1'b0;
    reg  [3:0]  peer_req = 4'h0;
    reg  [11:0] peer_prio = 12'h000;
    reg  [3:0]  peer_lock = 4'h0;
    reg  [1:0]  stall = 2'h1;
    reg  [15:0] rd;
    reg  [15:0] ctl;
    reg  [20:0] arb [0:4];
    reg         wacc_d = 1'b0;
    wire [31:0] avs_readdata;
    wire [31:0] m_address;
    wire [31:0] m_writedata;
    wire [31:0] m_readdata;
    wire [2:0]  bus_prio;
    wire [1:0]  m_width;
    wire        avs_waitrequest, bus_req, bus_lock, m_read, m_write, m_waitrequest, irq;
    integer     err_total = 0, total_checks = 0, irq_cnt = 0, gaps = 0, locks = 0;
    integer     i, j, w0, r0, q0, g0, l0;
    dma_channel_engine #(.NUM_CH(4), .CH_ID(1)) i_dma_channel_engine (.SYS_CLK(sys_clk),
        .SRST(srst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .PERIPH_REQ(periph_req), .PEER_REQ(peer_req),
        .PEER_PRIO(peer_prio), .PEER_LOCK(peer_lock), .BUS_REQ(bus_req), .BUS_PRIO(bus_prio),
        .BUS_LOCK(bus_lock), .M_ADDRESS(m_address), .M_READ(m_read), .M_WRITE(m_write),
        .M_WRITEDATA(m_writedata), .M_WIDTH(m_width), .M_READDATA(m_readdata),
        .M_WAITREQUEST(m_waitrequest), .IRQ(irq));
    mem_partner i_mem_partner (.clk(sys_clk), .rst(srst), .addr(m_address), .rd(m_read),
        .wr(m_write), .wdata(m_writedata), .stall(stall), .rdata(m_readdata),
        .waitreq(m_waitrequest));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Counts interrupt pulses, bus lock cycles and bus release cycles after a store.
    always @(negedge sys_clk) begin
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (bus_lock === 1'b1) locks <= locks + 1;
        if (wacc_d && bus_req === 1'b0) gaps <= gaps + 1;
        wacc_d <= m_write & ~m_waitrequest;
    end
    task report_and_stop;
        begin
            if (err_total == 0 && total_checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task avs(input wr, input [31:0] a, input [15:0] d);
        integer n;
        begin
            n = 0;
            @(posedge sys_clk);
            avs_address <= a;
            avs_writedata <= {16'h0000, d};
            avs_read <= ~wr;
            avs_write <= wr;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0 && n < 50) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            if (n >= 50) check(32'h0, 32'h1, "waitreq");
            rd = avs_readdata[15:0];
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task rchk(input [31:0] a, input [15:0] e, input [8*8:1] what);
        begin
            avs(1'b0, a, 16'h0000);
            check({16'h0000, rd}, {16'h0000, e}, what);
        end
    endtask
    task setup(input [31:0] s, input [31:0] d, input [15:0] len, input [15:0] thr);
        begin
            avs(1'b1, `IDX_SRC_START_LOW, s[15:0]);
            avs(1'b1, `IDX_SRC_START_HIGH, s[31:16]);
            avs(1'b1, `IDX_DST_START_LOW, d[15:0]);
            avs(1'b1, `IDX_DST_START_HIGH, d[31:16]);
            avs(1'b1, `IDX_IRQ_THRESHOLD, thr);
            avs(1'b1, `IDX_XFER_LENGTH, len);
        end
    endtask
    task wait_off;
        integer k;
        begin
            k = 0;
            rd = 16'hFFFF;
            while (rd[0] !== 1'b0 && k < 300) begin
                avs(1'b0, `IDX_CONTROL_WORD, 16'h0000);
                k = k + 1;
            end
        end
    endtask
    initial begin
        #300000;
        err_total = err_total + 1;
        report_and_stop;
    end
    initial begin
        arb[0] = {1'b0, 4'h0, 4'h1, 12'h003};
        arb[1] = {1'b1, 4'h0, 4'h4, 12'h0C0};
        arb[2] = {1'b0, 4'h0, 4'h8, 12'h800};
        arb[3] = {1'b1, 4'h0, 4'h1, 12'h002};
        arb[4] = {1'b0, 4'h4, 4'h4, 12'h000};
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        for (i = 0; i < 9; i = i + 1) rchk(32'h5000_361E + 2 * i, 16'h0000, "reset");
        for (i = 1; i < 7; i = i + 1) begin
            avs(1'b1, 32'h5000_361E + 2 * i, 16'hA5C3 + i[15:0]);
            rchk(32'h5000_361E + 2 * i, 16'hA5C3 + i[15:0], "rw");
        end
        avs(1'b1, `IDX_ITEM_INDEX, 16'h1234);
        rchk(`IDX_ITEM_INDEX, 16'h0000, "index");
        avs(1'b1, `IDX_CONTROL_WORD, 16'hFF00);
        rchk(`IDX_CONTROL_WORD, 16'h3F00, "ctrl");
        check({29'h0, bus_prio}, 32'h7, "prio");
        avs(1'b1, `IDX_CONTROL_WORD, 16'h0000);
        for (i = 0; i < 3; i = i + 1) begin
            stall <= i[1:0];
            setup(32'h0001_0100, 32'h0002_0200, 16'h0002, 16'h0001);
            w0 = i_mem_partner.wr_cnt;
            q0 = irq_cnt;
            g0 = gaps;
            l0 = locks;
            ctl = 16'h0069 | {13'h0, i[1:0], 1'b0} | ((i == 2) ? 16'h0800 : 16'h0000);
            avs(1'b1, `IDX_CONTROL_WORD, ctl);
            wait_off;
            check({16'h0000, rd}, {16'h0000, ctl & 16'hFFFE}, "on_clr");
            for (j = 0; j < 3; j = j + 1) begin
                check(i_mem_partner.wr_addr[w0 + j], 32'h0002_0200 + (j << i), "dst");
                check(i_mem_partner.wr_data[w0 + j], (32'h0001_0100 + (j << i)) ^ 32'h5A5A_0000, "data");
            end
            check(i_mem_partner.wr_cnt - w0, 3, "items");
            check(irq_cnt - q0, 1, "irq");
            check(gaps - g0, (i == 2) ? 3 : 1, "gaps");
            check(locks - l0 > 0, i != 2, "lock");
            check({30'h0, m_width}, i, "width");
            rchk(`IDX_ITEM_INDEX, 16'h0000, "idx_end");
        end
        stall <= 2'h1;
        setup(32'h0003_0000, 32'h0004_0000, 16'h0003, 16'h0001);
        w0 = i_mem_partner.wr_cnt;
        q0 = irq_cnt;
        r0 = i_mem_partner.rd_cnt;
        l0 = locks;
        avs(1'b1, `IDX_CONTROL_WORD, 16'h1061);
        wait_off;
        for (j = 0; j < 4; j = j + 1) begin
            check(i_mem_partner.wr_addr[w0 + j], 32'h0004_0000 + j, "fill_a");
            check(i_mem_partner.wr_data[w0 + j], 32'h5A59_0000, "fill_d");
        end
        check(i_mem_partner.rd_cnt - r0, 1, "fetches");
        check(locks - l0 > 0, 1, "fill_lk");
        check(irq_cnt - q0, 0, "irq_off");
        setup(32'h0005_0000, 32'h0006_0000, 16'h0001, 16'h0000);
        w0 = i_mem_partner.wr_cnt;
        avs(1'b1, `IDX_CONTROL_WORD, 16'h2071);
        repeat (20) @(posedge sys_clk);
        check(i_mem_partner.wr_cnt - w0, 0, "no_trig");
        periph_req <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check(i_mem_partner.wr_cnt - w0, 1, "edge_one");
        periph_req <= 1'b0;
        repeat (5) @(posedge sys_clk);
        periph_req <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check(i_mem_partner.wr_cnt - w0, 2, "edge_two");
        rchk(`IDX_CONTROL_WORD, 16'h2070, "trig_end");
        setup(32'h0007_0000, 32'h0008_0000, 16'h0000, 16'h0000);
        w0 = i_mem_partner.wr_cnt;
        avs(1'b1, `IDX_CONTROL_WORD, 16'h00F1);
        repeat (60) @(posedge sys_clk);
        check(i_mem_partner.wr_cnt - w0 > 1, 1, "circ");
        periph_req <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rchk(`IDX_CONTROL_WORD, 16'h00F1, "circ_on");
        rchk(`IDX_ITEM_INDEX, 16'h0000, "circ_idx");
        avs(1'b1, `IDX_CONTROL_WORD, 16'h0000);
        for (i = 0; i < 5; i = i + 1) begin
            peer_prio <= arb[i][11:0];
            peer_req <= arb[i][15:12];
            peer_lock <= arb[i][19:16];
            w0 = i_mem_partner.wr_cnt;
            avs(1'b1, `IDX_CONTROL_WORD, 16'h0361);
            repeat (30) @(posedge sys_clk);
            check(i_mem_partner.wr_cnt - w0, arb[i][20], "grant");
            peer_req <= 4'h0;
            peer_lock <= 4'h0;
            wait_off;
        end
        report_and_stop;
    end
endmodule // dma_channel_engine_tb
